// *** drive_enable_pkg.sv ***
// Functional notes
// - Reset runs self test, then switch-on-disabled
// - Bits 0..3 decoded together as command
// - Shutdown, switch on, enable, disable, quick stop
// - Shutdown needs enable input; stepwise power-up
// - Shutdown or disable voltage powers stage off
// - Quick stop disables, or brakes from operation
// - Rapid halt ends on braking done
// - Errors after self test enter fault reaction; critical goes direct
// - Fault state: stage off, brake engaged if fitted
// - Fault reset on bit 7 rising, cause gone
// - Stage off: no drive, brake engaged if fitted and out of reset
// - Stage on: brake released; mode bits only in operation enabled
// - Command word 16-bit read-write, resets zero
// - Bits 4,5,6,8 are mode dependent
// - Armed state waits for hardware enable input
package drive_enable_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] CMD_WORD_INDEX = 16'h6040;
    localparam logic [15:0] CMD_WORD_RESET = 16'h0000;

    // ==========================================
    // Command word field positions
    localparam int BIT_SWITCH_ON = 0;
    localparam int BIT_VOLTAGE = 1;
    localparam int BIT_NO_QSTOP = 2;
    localparam int BIT_ENABLE_OP = 3;
    localparam int BIT_SETPOINT = 4;
    localparam int BIT_IMMEDIATE = 5;
    localparam int BIT_RELATIVE = 6;
    localparam int BIT_FAULT_RESET = 7;
    localparam int BIT_HALT = 8;

    // ==========================================
    // Timing: self test length
    localparam int CLOCK_HZ = 10000000;
    localparam int SELFTEST_US = 100;
    localparam int SELFTEST_CYCLES = SELFTEST_US * (CLOCK_HZ / 1000000);

    // ==========================================
    // Drive states
    typedef enum logic [2:0] {
        selftest_state,
        switch_on_disabled_state,
        armed_state,
        switched_on_state,
        operation_enabled_state,
        rapid_halt_state,
        fault_reaction_state,
        fault_state
    } drive_state_t;

    // Decoded command set
    typedef enum logic [2:0] {
        cmd_none,
        cmd_shutdown,
        cmd_switch_on,
        cmd_enable_op,
        cmd_disable_op,
        cmd_quick_stop,
        cmd_disable_voltage
    } drive_cmd_t;

    // Mode dependent bits passed to motion logic
    typedef struct packed {
        logic setpoint;
        logic immediate;
        logic relative;
        logic halt;
    } mode_bits_t;

    // Register write request
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [15:0] data;
    } reg_write_t;

endpackage : drive_enable_pkg

// *** command_decoder.sv ***
`timescale 1ns/1ps
module command_decoder (
    // Command word bits 3..0
    input wire logic [3:0] code_in,
    // Decoded command
    output drive_enable_pkg::drive_cmd_t cmd_out
);
    import drive_enable_pkg::*;

    // Joint decode, most general pattern first
    always_comb begin
        if (!code_in[BIT_VOLTAGE]) begin
            cmd_out = cmd_disable_voltage;
        end else if (!code_in[BIT_NO_QSTOP]) begin
            cmd_out = cmd_quick_stop;
        end else if (!code_in[BIT_SWITCH_ON]) begin
            cmd_out = cmd_shutdown;
        end else if (code_in[BIT_ENABLE_OP]) begin
            cmd_out = cmd_enable_op;
        end else begin
            cmd_out = cmd_disable_op;
        end
    end
endmodule : command_decoder

// *** drive_enable_state_machine.sv ***
`timescale 1ns/1ps
module drive_enable_state_machine #(
    parameter int SELFTEST_LEN = drive_enable_pkg::SELFTEST_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Command word access
    input drive_enable_pkg::reg_write_t reg_wr_in,
    input wire logic [15:0] reg_rd_index_in,
    output logic [15:0] reg_rd_data_out,
    // Drive environment
    input wire logic hw_enable_input_in,
    input wire logic selftest_pass_in,
    input wire logic error_in,
    input wire logic error_critical_in,
    input wire logic error_cause_active_in,
    input wire logic reaction_done_in,
    input wire logic braking_done_in,
    input wire logic brake_fitted_in,
    // Drive control
    output drive_enable_pkg::drive_state_t state_out,
    output logic bus_comm_enable_out,
    output logic power_stage_enable_out,
    output logic brake_engage_out,
    output logic quick_stop_brake_out,
    output logic fault_reaction_brake_out,
    output drive_enable_pkg::mode_bits_t mode_bits_out
);
    import drive_enable_pkg::*;

    // ==========================================
    // Command word register
    logic [15:0] cmd_word_reg, cmd_word_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic fault_bit_reg, fault_bit_next;

    // Write stores word, read returns it
    always_comb begin
        cmd_word_next = cmd_word_reg;
        if (reg_wr_in.write && reg_wr_in.index == CMD_WORD_INDEX) begin
            cmd_word_next = reg_wr_in.data;
        end
        rd_data_next = (reg_rd_index_in == CMD_WORD_INDEX) ? cmd_word_reg : 16'h0000;
        fault_bit_next = cmd_word_reg[BIT_FAULT_RESET];
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cmd_word_reg <= CMD_WORD_RESET;
            rd_data_reg <= 16'h0000;
            fault_bit_reg <= 1'b0;
        end else begin
            cmd_word_reg <= cmd_word_next;
            rd_data_reg <= rd_data_next;
            fault_bit_reg <= fault_bit_next;
        end
    end

    // ==========================================
    // Decode of bits 3..0 only; bits 9..15 ignored
    drive_cmd_t cmd;
    logic fault_reset_edge;

    command_decoder u_decoder (
        .code_in(cmd_word_reg[3:0]),
        .cmd_out(cmd)
    );

    // Rising edge of fault reset bit
    assign fault_reset_edge = cmd_word_reg[BIT_FAULT_RESET] && !fault_bit_reg;

    // ==========================================
    // State machine
    drive_state_t state_reg, state_next;
    logic [31:0] test_cnt_reg, test_cnt_next;

    always_comb begin
        state_next = state_reg;
        test_cnt_next = test_cnt_reg;
        if (error_in && state_reg != fault_reaction_state && state_reg != fault_state
                && state_reg != selftest_state) begin
            // Critical errors skip the reaction
            state_next = error_critical_in ? fault_state : fault_reaction_state;
        end else begin
            case (state_reg)
                selftest_state: begin
                    if (test_cnt_reg < 32'(SELFTEST_LEN)) begin
                        test_cnt_next = test_cnt_reg + 32'd1;
                    end else if (selftest_pass_in) begin
                        state_next = switch_on_disabled_state;
                    end
                end
                switch_on_disabled_state: begin
                    if (cmd == cmd_shutdown && hw_enable_input_in) begin
                        state_next = armed_state;
                    end
                end
                armed_state: begin
                    if (cmd == cmd_disable_voltage || cmd == cmd_quick_stop) begin
                        state_next = switch_on_disabled_state;
                    end else if ((cmd == cmd_switch_on || cmd == cmd_enable_op
                            || cmd == cmd_disable_op) && hw_enable_input_in) begin
                        state_next = switched_on_state;
                    end
                end
                switched_on_state: begin
                    if (cmd == cmd_disable_voltage || cmd == cmd_quick_stop) begin
                        state_next = switch_on_disabled_state;
                    end else if (cmd == cmd_shutdown) begin
                        state_next = armed_state;
                    end else if (cmd == cmd_enable_op) begin
                        state_next = operation_enabled_state;
                    end
                end
                operation_enabled_state: begin
                    if (cmd == cmd_disable_voltage) begin
                        state_next = switch_on_disabled_state;
                    end else if (cmd == cmd_quick_stop) begin
                        state_next = rapid_halt_state;
                    end else if (cmd == cmd_shutdown) begin
                        state_next = armed_state;
                    end else if (cmd == cmd_disable_op) begin
                        state_next = switched_on_state;
                    end
                end
                rapid_halt_state: begin
                    if (braking_done_in || cmd == cmd_disable_voltage) begin
                        state_next = switch_on_disabled_state;
                    end
                end
                fault_reaction_state: begin
                    if (reaction_done_in) begin
                        state_next = fault_state;
                    end
                end
                fault_state: begin
                    if (fault_reset_edge && !error_cause_active_in) begin
                        state_next = switch_on_disabled_state;
                    end
                end
                default: begin
                    state_next = selftest_state;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= selftest_state;
            test_cnt_reg <= 32'd0;
        end else begin
            state_reg <= state_next;
            test_cnt_reg <= test_cnt_next;
        end
    end

    // ==========================================
    // Registered outputs from next state
    logic power_next, comm_next, brake_next;
    mode_bits_t mode_next;
    drive_state_t state_out_reg;
    logic comm_reg, power_reg, brake_reg, qs_reg, fr_reg;
    mode_bits_t mode_reg;

    always_comb begin
        power_next = (state_next == switched_on_state)
            || (state_next == operation_enabled_state)
            || (state_next == rapid_halt_state)
            || (state_next == fault_reaction_state);
        comm_next = (state_next != selftest_state);
        // Brake locked only when stage off and brake fitted
        brake_next = !power_next && brake_fitted_in;
        mode_next.setpoint = cmd_word_reg[BIT_SETPOINT];
        mode_next.immediate = cmd_word_reg[BIT_IMMEDIATE];
        mode_next.relative = cmd_word_reg[BIT_RELATIVE];
        mode_next.halt = cmd_word_reg[BIT_HALT];
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_out_reg <= selftest_state;
            comm_reg <= 1'b0;
            power_reg <= 1'b0;
            brake_reg <= 1'b0;
            qs_reg <= 1'b0;
            fr_reg <= 1'b0;
            mode_reg <= '0;
        end else begin
            state_out_reg <= state_next;
            comm_reg <= comm_next;
            power_reg <= power_next;
            brake_reg <= brake_next;
            qs_reg <= (state_next == rapid_halt_state);
            fr_reg <= (state_next == fault_reaction_state);
            mode_reg <= (state_next == operation_enabled_state) ? mode_next : '0;
        end
    end

    assign reg_rd_data_out = rd_data_reg;
    assign state_out = state_out_reg;
    assign bus_comm_enable_out = comm_reg;
    assign power_stage_enable_out = power_reg;
    assign brake_engage_out = brake_reg;
    assign quick_stop_brake_out = qs_reg;
    assign fault_reaction_brake_out = fr_reg;
    assign mode_bits_out = mode_reg;

endmodule : drive_enable_state_machine

// *** drive_enable_state_machine_checker.sv ***
`timescale 1ns/1ps
module drive_enable_state_machine_checker
import drive_enable_pkg::*;
#(parameter int SELFTEST_LEN = SELFTEST_CYCLES) (
    // Clock, reset and environment
    input wire logic clock_in, rst_n_in, hw_enable_input_in, error_in,
    input wire logic error_critical_in, error_cause_active_in, braking_done_in,
    input wire logic brake_fitted_in,
    input wire logic [15:0] reg_rd_index_in,
    // Watched outputs
    input wire logic [15:0] reg_rd_data_out,
    input drive_enable_pkg::drive_state_t state_out,
    input wire logic bus_comm_enable_out, power_stage_enable_out, brake_engage_out,
    input wire logic quick_stop_brake_out, fault_reaction_brake_out,
    input drive_enable_pkg::mode_bits_t mode_bits_out
);
    // ==========================================
    // Clocking and step sequences
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    wire logic run = state_out inside {switch_on_disabled_state, armed_state,
        switched_on_state, operation_enabled_state, rapid_halt_state};
    sequence s_arm;
        state_out == switch_on_disabled_state ##1 state_out == armed_state;
    endsequence
    sequence s_unfault;
        state_out == fault_state ##1 state_out == switch_on_disabled_state;
    endsequence
    // ==========================================
    // Assertions
    a_stage_map: assert property (power_stage_enable_out == (state_out inside {
        switched_on_state, operation_enabled_state, rapid_halt_state,
        fault_reaction_state})) else $error("power stage level wrong");
    a_brake_lock: assert property ($past(rst_n_in) |-> brake_engage_out ==
        (!power_stage_enable_out && $past(brake_fitted_in))) else $error("brake wrong");
    a_comm_on: assert property (bus_comm_enable_out == (state_out != selftest_state))
        else $error("bus enable wrong");
    a_arm_enable: assert property (s_arm |-> $past(hw_enable_input_in))
        else $error("armed without enable");
    a_fault_exit: assert property (s_unfault |-> !$past(error_cause_active_in))
        else $error("fault left with cause");
    a_halt_done: assert property (state_out == rapid_halt_state && braking_done_in
        && !error_in |=> state_out == switch_on_disabled_state) else $error("halt stuck");
    a_error_entry: assert property (run && error_in |=> state_out ==
        ($past(error_critical_in) ? fault_state : fault_reaction_state))
        else $error("error not taken");
    a_qs_brake: assert property (quick_stop_brake_out == (state_out == rapid_halt_state))
        else $error("quick stop brake wrong");
    a_fr_brake: assert property (fault_reaction_brake_out ==
        (state_out == fault_reaction_state)) else $error("reaction brake wrong");
    a_mode_zero: assert property (state_out != operation_enabled_state |->
        mode_bits_out == '0) else $error("mode bits leak");
    a_read_other: assert property ($past(rst_n_in) && $past(reg_rd_index_in) !=
        CMD_WORD_INDEX |-> reg_rd_data_out == 16'h0000) else $error("read not zero");
endmodule : drive_enable_state_machine_checker
bind drive_enable_state_machine drive_enable_state_machine_checker
    #(.SELFTEST_LEN(SELFTEST_LEN)) u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .hw_enable_input_in(hw_enable_input_in), .error_in(error_in),
    .error_critical_in(error_critical_in), .error_cause_active_in(error_cause_active_in),
    .braking_done_in(braking_done_in), .brake_fitted_in(brake_fitted_in),
    .reg_rd_index_in(reg_rd_index_in), .reg_rd_data_out(reg_rd_data_out),
    .state_out(state_out), .bus_comm_enable_out(bus_comm_enable_out),
    .power_stage_enable_out(power_stage_enable_out), .brake_engage_out(brake_engage_out),
    .quick_stop_brake_out(quick_stop_brake_out), .mode_bits_out(mode_bits_out),
    .fault_reaction_brake_out(fault_reaction_brake_out));

// *** drive_enable_host.sv ***
`timescale 1ns/1ps
module drive_enable_host (
    // Clock
    input wire logic clock_in,
    // Write request
    output drive_enable_pkg::reg_write_t reg_wr_out
);
    import drive_enable_pkg::*;
    // Idle bus shows inverted data, never a stale word
    initial reg_wr_out = '{1'b0, 16'h0000, 16'hFFFF};
    // One-cycle write pulse from the falling edge
    task automatic put(input logic [15:0] idx, input logic [15:0] w);
        @(negedge clock_in);
        reg_wr_out = '{1'b1, idx, w};
        @(negedge clock_in);
        reg_wr_out = '{1'b0, ~idx, ~w};
    endtask : put
endmodule : drive_enable_host

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import drive_enable_pkg::*;
    // ==========================================
    // Signals
    localparam logic [15:0] W = CMD_WORD_INDEX;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] rd_index = 16'h0000;
    logic [15:0] rd_data;
    logic hw_en = 1'b0, st_pass = 1'b1, err = 1'b0, crit = 1'b0;
    logic cause = 1'b0, re_done = 1'b0, bk_done = 1'b0, bk_fit = 1'b1;
    logic comm, power, brake, qs_brk, fr_brk;
    reg_write_t reg_wr;
    drive_state_t state;
    mode_bits_t mode;
    int num_errors = 0;
    int cmp_count = 0;
    // Clock
    always #50 clock_in = ~clock_in;
    // ==========================================
    // Host and design
    drive_enable_host u_host (.clock_in(clock_in), .reg_wr_out(reg_wr));
    drive_enable_state_machine #(.SELFTEST_LEN(4)) u_dut (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .reg_wr_in(reg_wr), .reg_rd_index_in(rd_index),
        .reg_rd_data_out(rd_data), .hw_enable_input_in(hw_en), .selftest_pass_in(st_pass),
        .error_in(err), .error_critical_in(crit), .error_cause_active_in(cause),
        .reaction_done_in(re_done), .braking_done_in(bk_done), .brake_fitted_in(bk_fit),
        .state_out(state), .bus_comm_enable_out(comm), .power_stage_enable_out(power),
        .brake_engage_out(brake), .quick_stop_brake_out(qs_brk),
        .fault_reaction_brake_out(fr_brk), .mode_bits_out(mode));
    // ==========================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Write, wait out the answer, compare state
    task automatic go(input logic [15:0] idx, input logic [15:0] w, input drive_state_t e);
        u_host.put(idx, w);
        repeat (4) @(negedge clock_in);
        chk("state", 16'(e), 16'(state));
    endtask : go
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // Scenarios
    task automatic t_reset;
        repeat (2) @(negedge clock_in);
        chk("reset state", 16'(selftest_state), 16'(state));
        rst_n_in = 1'b1;
        rd_index = W;
        @(negedge clock_in);
        chk("comm", 16'h0000, 16'(comm));
        chk("word", CMD_WORD_RESET, rd_data);
        repeat (8) @(negedge clock_in);
        chk("ready", 16'(switch_on_disabled_state), 16'(state));
    endtask : t_reset
    task automatic t_power;
        go(W, 16'h0006, switch_on_disabled_state);
        hw_en = 1'b1;
        go(W, 16'h0006, armed_state);
        go(W, 16'h0007, switched_on_state);
        chk("brake", 16'h0000, 16'(brake));
        go(W, 16'h017F, operation_enabled_state);
        chk("mode", 16'h000F, 16'(mode));
        go(16'h6041, 16'h0000, operation_enabled_state);
        chk("word", 16'h017F, rd_data);
        go(W, 16'h0007, switched_on_state);
        go(W, 16'h0006, armed_state);
        chk("brake", 16'h0001, 16'(brake));
        rd_index = 16'h6041;
        @(negedge clock_in);
        chk("unmapped", 16'h0000, rd_data);
    endtask : t_power
    task automatic t_stop;
        go(W, 16'h0002, switch_on_disabled_state);
        go(W, 16'h0006, armed_state);
        go(W, 16'h000F, operation_enabled_state);
        go(W, 16'h000B, rapid_halt_state);
        chk("halt power", 16'h0001, 16'(power));
        bk_done = 1'b1;
        go(W, 16'h000B, switch_on_disabled_state);
        bk_done = 1'b0;
        go(W, 16'h0006, armed_state);
        go(W, 16'h000F, operation_enabled_state);
        go(W, 16'h0000, switch_on_disabled_state);
    endtask : t_stop
    task automatic t_fault;
        go(W, 16'h0006, armed_state);
        go(W, 16'h000F, operation_enabled_state);
        err = 1'b1;
        @(negedge clock_in);
        err = 1'b0;
        @(negedge clock_in);
        chk("reaction", 16'(fault_reaction_state), 16'(state));
        cause = 1'b1;
        re_done = 1'b1;
        go(W, 16'h0080, fault_state);
        re_done = 1'b0;
        chk("fault power", 16'h0000, 16'(power));
        cause = 1'b0;
        go(W, 16'h0080, fault_state);
        go(W, 16'h0000, fault_state);
        go(W, 16'h0080, switch_on_disabled_state);
        go(W, 16'h0006, armed_state);
        err = 1'b1;
        crit = 1'b1;
        @(negedge clock_in);
        err = 1'b0;
        crit = 1'b0;
        @(negedge clock_in);
        chk("critical", 16'(fault_state), 16'(state));
    endtask : t_fault
    // ==========================================
    // Main sequence and watchdog
    initial begin
        t_reset();
        t_power();
        t_stop();
        t_fault();
        end_sim();
    end
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule : tb
